// ===== mcs_consts.svh
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH

// register map (byte addresses)
`define MCS_OFF_CTRL      12'h000
`define MCS_OFF_ADDR      12'h004
`define MCS_OFF_STATUS    12'h008
`define MCS_OFF_RESULT    12'h00c
`define MCS_OFF_DETECT    12'h010

// control register fields
`define MCS_CTRL_LOAD_SEL   0
`define MCS_CTRL_CLEAR_SEL  1
`define MCS_CTRL_COUNT_EN   2
`define MCS_CTRL_MUX_EN     3
`define MCS_CTRL_TWOS       4
`define MCS_CTRL_DET_EN     5
`define MCS_CTRL_CYC_LSB    8
`define MCS_CTRL_RESET      32'h0000_000f

// status register fields
`define MCS_STAT_EOC        0
`define MCS_STAT_DET        1
`define MCS_STAT_CARRY      2

// data widths
`define MCS_RES_BITS        12
`define MCS_ADDR_BITS       8

// settling delay 6 us at 4 ns clock
`define MCS_DELAY_NS        6000
`define MCS_CLK_NS          4
`define MCS_DELAY_CYC       (`MCS_DELAY_NS / `MCS_CLK_NS)

`endif

// ===== mcs_pkg.sv
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_IDLE,
    MCS_SETTLE,
    MCS_CONVERT
  } mcs_state_t;
endpackage : mcs_pkg

// ===== mcs_edge.sv
`timescale 1ns/10ps
`include "mcs_consts.svh"

// edge finder on a pin taken as synchronous
module mcs_edge (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic last_reg;
  logic armed_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b1;
    end else begin
      last_reg <= pin;
    end
  end

  // pins idle at either level, so no edge until one real sample is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  assign rise = armed_reg & pin & ~last_reg;
  assign fall = armed_reg & ~pin & last_reg;
endmodule : mcs_edge

// ===== mcs_sar.sv
`timescale 1ns/10ps
`include "mcs_consts.svh"

// successive approximation model, one bit a cycle, msb first
module mcs_sar (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // control
  input  wire logic                       start,
  input  wire logic [3:0]                 cycle_bits,
  input  wire logic [`MCS_RES_BITS-1:0]   analog,
  // result
  output logic                            busy,
  output logic                            done,
  output logic [`MCS_RES_BITS-1:0]        result
);
  logic [`MCS_RES_BITS-1:0] trial_reg;
  logic [3:0]               bit_reg;
  logic [3:0]               stop_bit;

  // 0 or anything above 12 means full resolution; n from 1 to 12 stops after n bits
  assign stop_bit = (cycle_bits == 4'h0 || cycle_bits > 4'hc) ? 4'hc : cycle_bits; // RL1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      bit_reg   <= 4'h0;
      trial_reg <= '0;
      result    <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        bit_reg   <= 4'h0;
        trial_reg <= '0;
      end else if (busy) begin
        // untested low bits stay zero, span 000 to fff
        if (analog[4'hb - bit_reg]) begin
          trial_reg[4'hb - bit_reg] <= 1'b1; // RL10
        end
        if (bit_reg + 4'h1 == stop_bit) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= trial_reg | (analog & ({`MCS_RES_BITS{1'b1}} << (4'hb - bit_reg))
                    & ({`MCS_RES_BITS{1'b1}} >> bit_reg)); // RL1
        end
        bit_reg <= bit_reg + 4'h1;
      end
    end
  end
endmodule : mcs_sar

// ===== mcs_top.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "mcs_consts.svh"

// Functional notes
// RL1: full 12 bits, or stop after n
// RL2: host holds enables low when short-cycled
// RL3: msb select gives binary or twos complement
// RL4: free-run scans while positive trigger high
// RL5: strobe fall increments address counter
// RL6: load-select low loads external address
// RL7: conversion starts after settling delay ends
// RL8: host clears address with clear-select low
// RL9: host may pulse positive trigger for calibration
// RL10: result spans all zeros to all ones
// RL11: counter, decoder and detector present
// RL12: detector short-cycles the channel scan
// RL13: no-counter variant allows random addressing only
// RL14: address supports up to 256 channels
// RL15: clear-select low makes strobe zero counter
// RL16: count enable low inhibits the counter
// RL17: eoc high during each conversion
// RL18: counter wraps to zero and continues
// RL19: channel held as binary until strobe
module mcs_top
  import mcs_pkg::*;
(
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // host pins
  input  wire logic                       strobe_pin,
  input  wire logic                       trig_pos_pin,
  input  wire logic [`MCS_ADDR_BITS-1:0]  addr_in_pin,
  input  wire logic [`MCS_RES_BITS-1:0]   analog_in,
  // device outputs
  output logic [`MCS_ADDR_BITS-1:0]       addr_out,
  output logic [2:0]                      bank_en,
  output logic                            mux_on,
  output logic                            delay_out,
  output logic                            eoc,
  output logic                            carry_out,
  output logic                            detect_out,
  output logic [`MCS_RES_BITS-1:0]        data_out
);

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]                ctrl_reg;
  logic [`MCS_ADDR_BITS-1:0]  addr_reg;
  logic [`MCS_ADDR_BITS-1:0]  detect_reg;
  logic [`MCS_RES_BITS-1:0]   result_reg;
  logic [12:0]                delay_cnt_reg;
  logic                       free_run_reg;
  mcs_state_t                 state_reg;

  logic                       strobe_fall;
  logic                       strobe_rise;
  logic                       trig_rise;
  logic                       trig_fall;
  logic                       sar_busy;
  logic                       sar_done;
  logic [`MCS_RES_BITS-1:0]   sar_result;
  logic                       wr_en;
  logic                       rd_en;
  logic                       det_hit;
  logic                       strobe_evt;
  logic                       pos_start;
  logic                       clr_sel;

  ////////////////////////////////////////////////////////////////////
  // pin edges
  mcs_edge u_strobe_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (strobe_pin),
    .rise    (strobe_rise),
    .fall    (strobe_fall)
  );

  mcs_edge u_trig_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (trig_pos_pin),
    .rise    (trig_rise),
    .fall    (trig_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // apb access, zero wait states
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `MCS_CTRL_RESET;
      detect_reg <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        `MCS_OFF_CTRL:   ctrl_reg   <= pwdata;
        `MCS_OFF_DETECT: detect_reg <= pwdata[`MCS_ADDR_BITS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // ready rises in setup so the access completes at once
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        unique case (paddr)
          `MCS_OFF_CTRL:   prdata <= ctrl_reg;
          `MCS_OFF_ADDR:   prdata <= {24'h000000, addr_reg};
          `MCS_OFF_STATUS: prdata <= {29'h0, carry_out, det_hit, eoc};
          `MCS_OFF_RESULT: prdata <= {20'h00000, result_reg};
          `MCS_OFF_DETECT: prdata <= {24'h000000, detect_reg};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // free-running mode: the converter's done pulse feeds the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_run_reg <= 1'b0;
    end else if (trig_rise) begin
      free_run_reg <= 1'b1; // RL4
    end else if (trig_fall) begin
      free_run_reg <= 1'b0; // RL4
    end
  end

  // strobe event: pin fall, or end of conversion while free running
  assign strobe_evt = strobe_fall | (free_run_reg & trig_pos_pin & sar_done); // RL4
  assign pos_start  = trig_rise;
  // detector hit forces clear, like the detector output tied to clear-select
  assign det_hit = ctrl_reg[`MCS_CTRL_DET_EN] & ((addr_reg & detect_reg) == detect_reg); // RL12
  assign clr_sel = ~ctrl_reg[`MCS_CTRL_CLEAR_SEL] | det_hit;

  ////////////////////////////////////////////////////////////////////
  // channel address counter / register
  logic [`MCS_ADDR_BITS-1:0]  addr_next;
  logic                       carry_next;

  // priority: clear, then load, then count
  always_comb begin
    addr_next  = addr_reg;
    carry_next = carry_out;
    if (strobe_evt) begin
      carry_next = 1'b0;
      if (clr_sel) begin
        addr_next = '0; // RL15 RL12
      end else if (!ctrl_reg[`MCS_CTRL_LOAD_SEL]) begin
        addr_next = addr_in_pin; // RL6 RL13
      end else if (ctrl_reg[`MCS_CTRL_COUNT_EN]) begin
        // wraps 255 to 0, carry marks each low-nibble rollover from f to 0 for second level
        addr_next  = addr_reg + 8'h01; // RL5 RL16 RL18 RL14
        carry_next = (addr_reg[3:0] == 4'hf); // RL11
      end
    end
  end

  // only a strobe event moves these, so they hold between strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= '0;
      carry_out <= 1'b0;
    end else begin
      addr_reg  <= addr_next;
      carry_out <= carry_next;
    end
  end

  // address output follows the address register a cycle later, so it moves only after a strobe event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out <= '0;
    end else begin
      addr_out <= addr_reg; // RL19
    end
  end

  // mux enable follows the control bit a cycle later, no strobe needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_on <= 1'b0;
    end else begin
      mux_on <= ctrl_reg[`MCS_CTRL_MUX_EN];
    end
  end

  // decoder selects a 16-channel bank from bits 4 and 5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_en <= 3'h0;
    end else begin
      bank_en[0] <= ctrl_reg[`MCS_CTRL_MUX_EN] & (addr_reg[5:4] == 2'h0); // RL11
      bank_en[1] <= ctrl_reg[`MCS_CTRL_MUX_EN] & (addr_reg[5:4] == 2'h1);
      bank_en[2] <= ctrl_reg[`MCS_CTRL_MUX_EN] & (addr_reg[5:4] == 2'h2);
    end
  end

  // active low, as an open detector output would be
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_out <= 1'b1;
    end else begin
      detect_out <= ~det_hit; // RL12
    end
  end

  ////////////////////////////////////////////////////////////////////
  // settling delay then conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= MCS_IDLE;
      delay_cnt_reg <= '0;
      delay_out     <= 1'b0;
    end else begin
      unique case (state_reg)
        MCS_IDLE: begin
          if (strobe_evt || pos_start) begin
            state_reg     <= MCS_SETTLE;
            delay_cnt_reg <= 13'(`MCS_DELAY_CYC - 1);
            delay_out     <= 1'b1;
          end
        end
        MCS_SETTLE: begin
          if (delay_cnt_reg == 13'h0000) begin
            // falling edge of delay starts the converter
            delay_out <= 1'b0; // RL7
            state_reg <= MCS_CONVERT;
          end else begin
            delay_cnt_reg <= delay_cnt_reg - 13'h0001;
          end
        end
        MCS_CONVERT: begin
          // free-run: the end of one conversion strobes the next,
          // which the idle state would never see since done is a pulse
          if (sar_done && strobe_evt) begin
            state_reg     <= MCS_SETTLE;
            delay_cnt_reg <= 13'(`MCS_DELAY_CYC - 1);
            delay_out     <= 1'b1; // RL4 RL7
          end else if (sar_done) begin
            state_reg <= MCS_IDLE;
          end
        end
      endcase
    end
  end

  mcs_sar u_sar (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (state_reg == MCS_CONVERT && !sar_busy && !sar_done), // RL7
    .cycle_bits (ctrl_reg[`MCS_CTRL_CYC_LSB +: 4]),
    .analog     (analog_in),
    .busy       (sar_busy),
    .done       (sar_done),
    .result     (sar_result)
  );

  // eoc follows the converter's busy flag, one cycle a bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc <= 1'b0;
    end else begin
      eoc <= sar_busy; // RL17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
      data_out   <= '0;
    end else if (sar_done) begin
      result_reg <= sar_result; // RL10
      // msb select: true msb binary, inverted msb twos complement
      data_out <= {sar_result[11] ^ ctrl_reg[`MCS_CTRL_TWOS], sar_result[10:0]}; // RL3
    end
  end

  // strobe_rise unused by design beyond edge tracking
  logic unused_ok;
  assign unused_ok = strobe_rise;

endmodule : mcs_top

// ===== mcs_props.sv
`timescale 1ns/10ps
module mcs_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        strobe_pin,
  input wire logic        trig_pos_pin,
  input wire logic [7:0]  addr_out,
  input wire logic [2:0]  bank_en,
  input wire logic        mux_on,
  input wire logic        delay_out,
  input wire logic        eoc
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] dcnt;
  logic [3:0]  ecnt;
  logic [2:0]  scnt;
  // scnt saturates so a long idle spell cannot wrap it back to zero; dcnt and ecnt count only while their signal is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt <= 11'h0;
      ecnt <= 4'h0;
      scnt <= 3'h7;
    end else begin
      dcnt <= delay_out ? dcnt + 11'h1 : 11'h0;
      ecnt <= eoc ? ecnt + 4'h1 : 4'h0;
      scnt <= $fell(strobe_pin) ? 3'h0 : (scnt == 3'h7 ? scnt : scnt + 3'h1);
    end
  end
  a_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_unmapped_err: assert property (pready && paddr > 12'h010 |-> pslverr) else $error("no error on unmapped");
  a_delay_len: assert property ($fell(delay_out) |-> dcnt == 11'h5dc)
    else $error("settling pulse length wrong");
  a_conv_follows: assert property ($fell(delay_out) |-> ##[0:2] eoc)
    else $error("no conversion after settling");
  a_eoc_len: assert property ($fell(eoc) |-> ecnt != 4'h0 && ecnt <= 4'hc)
    else $error("conversion length wrong");
  a_no_overlap: assert property (!(delay_out && eoc)) else $error("busy during settling");
  a_addr_hold: assert property ($changed(addr_out) |-> scnt < 3'h4 || trig_pos_pin)
    else $error("address moved without strobe");
  a_bank_off: assert property (!mux_on && !$past(mux_on) |-> bank_en == 3'h0)
    else $error("bank enabled while mux off");
  a_bank_single: assert property ($onehot0(bank_en)) else $error("two banks enabled");
  c_conv: cover property ($fell(eoc));
  c_err: cover property (pready && pslverr);
  c_free: cover property (trig_pos_pin && $fell(eoc));
endmodule : mcs_props

bind mcs_top mcs_props u_props (.*);

// ===== mcs_host.sv
`timescale 1ns/10ps
module mcs_host (
  // clock
  input wire logic  pclk,
  // host pins
  output logic       strobe_pin,
  output logic       trig_pos_pin,
  output logic [7:0] addr_in_pin
);
  initial begin
    strobe_pin = 1'b1;
    trig_pos_pin = 1'b0;
    addr_in_pin = 8'h00;
  end
  // short low pulse, address kept 300 ns past the edge then scrambled
  task automatic strobe(input logic [7:0] a);
    @(posedge pclk);
    strobe_pin <= 1'b0;
    addr_in_pin <= a;
    repeat (2) @(posedge pclk);
    strobe_pin <= 1'b1;
    repeat (75) @(posedge pclk);
    addr_in_pin <= ~a;
  endtask : strobe
  task automatic trig(input logic lvl);
    @(posedge pclk);
    trig_pos_pin <= lvl;
  endtask : trig
endmodule : mcs_host

// ===== tb_mux_channel_sequencer.sv
`timescale 1ns/10ps
module tb_mux_channel_sequencer;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr, analog_in;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, strobe_pin, trig_pos_pin, mux_on, delay_out, eoc, er, carry_out, detect_out;
  logic [7:0] addr_in_pin, addr_out, e, s, a;
  logic [2:0] bank_en;
  logic [11:0] data_out, v;
  logic [3:0] n;
  int fail_count = 0, checked = 0, seed = 91774, i;
  always #2 pclk = ~pclk;
  mcs_host u_host (.pclk(pclk), .strobe_pin(strobe_pin), .trig_pos_pin(trig_pos_pin),
    .addr_in_pin(addr_in_pin));
  mcs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strobe_pin(strobe_pin), .trig_pos_pin(trig_pos_pin), .addr_in_pin(addr_in_pin),
    .analog_in(analog_in), .addr_out(addr_out), .bank_en(bank_en), .mux_on(mux_on),
    .delay_out(delay_out), .eoc(eoc), .carry_out(carry_out), .detect_out(detect_out), .data_out(data_out));
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic wait_done();
    while (eoc !== 1'b1) @(posedge pclk);
    while (eoc !== 1'b0) @(posedge pclk);
    @(posedge pclk);
  endtask : wait_done
  function automatic logic [11:0] exp_res(logic [11:0] x, logic [3:0] b, logic tw);
    exp_res = (x & (b == 0 ? 12'hfff : ~(12'hfff >> b))) ^ {tw, 11'h0};
  endfunction : exp_res
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge pclk);
    fail_count++;
    summarize();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    analog_in = 12'h000;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0); chk(r, 32'h0000000f);
    apb(1, 12'h004, 32'h55); apb(0, 12'h004, 0); chk(r, 0);
    apb(0, 12'h014, 0); chk({r, er}, 33'h1);
    e = 0;
    for (i = 0; i < 258; i++) begin
      u_host.strobe($random(seed)); e = e + 8'h1; chk(addr_out, e);
      chk(carry_out, e[3:0] == 4'h0);
    end
    apb(1, 12'h000, 32'h0b); u_host.strobe(8'h3c); chk(addr_out, e);
    apb(1, 12'h000, 32'h0e);
    for (i = 0; i < 4; i++) begin
      a = $random(seed); u_host.strobe(a); chk(addr_out, a);
    end
    apb(1, 12'h000, 32'h0d); u_host.strobe(8'h7e); chk(addr_out, 0);
    apb(1, 12'h010, 32'h3); apb(1, 12'h000, 32'h2f); e = 0;
    for (i = 0; i < 5; i++) begin
      u_host.strobe(8'h00); e = (e == 3) ? 8'h0 : e + 8'h1; chk(addr_out, e);
      chk(detect_out, e != 8'h3);
    end
    // let any strobe-started conversion finish so the trigger finds the sequencer idle
    apb(1, 12'h000, 32'h07); repeat (1600) @(posedge pclk); chk(bank_en, 0);
    for (i = 0; i < 5; i++) begin
      n = (i == 3) ? 4'h8 : (i == 4 ? 4'ha : 4'h0);
      v = (i == 0) ? 12'h000 : (i == 1 ? 12'hfff : $random(seed));
      apb(1, 12'h000, {20'h0, n, 8'h0f} | (i == 2 ? 32'h10 : 0));
      analog_in <= v;
      u_host.trig(1); u_host.trig(0);
      repeat (3) @(posedge pclk);
      chk({delay_out, eoc}, 2'h2);
      wait_done();
      chk(data_out, exp_res(v, n, i == 2));
    end
    apb(1, 12'h000, 32'h0f); s = addr_out;
    u_host.trig(1); wait_done(); wait_done(); u_host.trig(0); wait_done();
    repeat (5) @(posedge pclk);
    chk({addr_out, delay_out}, {s + 8'h2, 1'b0});
    summarize();
  end
endmodule : tb_mux_channel_sequencer
